/* File: core/bss_sequencer.sv */
// burst sample sequencer: burst length, pacing, sample period, function select
// Notes on behaviour
// - burst length 1 to 16777215; that many readings per accepted trigger.
// - maximum burst length flags out-of-memory; streaming still proceeds.
// - configure operation and reset force burst length to one.
// - pacing selection matters only when burst length exceeds one.
// - immediate pacing starts next reading once engine is not busy.
// - timed pacing spaces readings by the sample period.
// - configure operation and reset select immediate pacing.
// - pacing source readable with distinct codes for immediate and timed.
// - sample period spaces burst readings and scan channel steps.
// - sample period 76 us to 65534 us; min and max select limits.
// - first reading of burst starts without waiting a period.
// - delay before first reading belongs to trigger delay, not timer.
// - reset sets sample period to 50 ms.
// - queries return present value, or min or max limit when qualified.
// - function select: four-wire ohms, ac volts, dc volts; dc at reset.
// - dc volts selected with or without explicit dc qualifier.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module bss_sequencer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// trigger and measurement engine
	input wire logic trigAccepted,
	input wire logic engineBusy,
	input wire logic readingDone,
	output logic readingStart,
	output logic burstActive,
	output logic scanStep,
	// mode and status
	input wire logic scanMode,
	output logic [1:0] measFunction,
	output logic outOfMemory
);
	// ==========================================================
	// submodules
	logic tick;
	bss_timer_if tif ();
	bss_tick_gen #(.CYCLES(bss_pkg::TICK_CYCLES)) u_tick (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tick(tick)
	);
	bss_period_timer u_timer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tick(tick),
		.tif(tif)
	);
	// ==========================================================
	// configuration state
	logic [bss_pkg::BURST_W-1:0] burst_q, burst_d;
	logic [bss_pkg::PERIOD_W-1:0] period_q, period_d;
	logic pace_q, pace_d;
	logic [1:0] func_q, func_d;
	logic [1:0] limSel_q, limSel_d;
	logic oom_q, oom_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic seqBusy;
	logic wrAcc, rdAcc, known;
	logic [1:0] funcWr;
	logic [bss_pkg::BURST_W-1:0] burstWr;
	logic [bss_pkg::PERIOD_W-1:0] periodWr;
	always_comb begin
		wrAcc = psel && penable && pwrite && !ready_q;
		rdAcc = psel && penable && !pwrite && !ready_q;
		known = (paddr == bss_pkg::OFF_BURST) || (paddr == bss_pkg::OFF_PERIOD) ||
			(paddr == bss_pkg::OFF_CTRL) || (paddr == bss_pkg::OFF_CMD) ||
			(paddr == bss_pkg::OFF_STATUS) || (paddr == bss_pkg::OFF_LIMIT);
		// clamp writes into the legal span
		burstWr = pwdata[bss_pkg::BURST_W-1:0];
		if (burstWr == '0) begin
			burstWr = bss_pkg::BURST_MIN;
		end
		periodWr = pwdata[bss_pkg::PERIOD_W-1:0];
		if (periodWr < bss_pkg::PERIOD_MIN_US) begin
			periodWr = bss_pkg::PERIOD_MIN_US;
		end else if (periodWr > bss_pkg::PERIOD_MAX_US) begin
			periodWr = bss_pkg::PERIOD_MAX_US;
		end
		funcWr = pwdata[bss_pkg::CTRL_FUNC_LO +: 2];
		if (funcWr == bss_pkg::BSS_DC_VOLTS_ALIAS) begin
			funcWr = bss_pkg::BSS_DC_VOLTS_FUNCTION;
		end
		burst_d = burst_q;
		period_d = period_q;
		pace_d = pace_q;
		func_d = func_q;
		limSel_d = limSel_q;
		oom_d = oom_q;
		if (wrAcc) begin
			unique case (paddr)
				bss_pkg::OFF_BURST: begin
					burst_d = burstWr;
					oom_d = (burstWr == bss_pkg::BURST_MAX);
				end
				bss_pkg::OFF_PERIOD: begin
					period_d = periodWr;
				end
				bss_pkg::OFF_CTRL: begin
					pace_d = pwdata[bss_pkg::CTRL_PACE_BIT];
					func_d = funcWr;
				end
				bss_pkg::OFF_CMD: begin
					if (pwdata[bss_pkg::CMD_CLR_ERR_BIT]) begin
						oom_d = 1'b0;
					end
					if (pwdata[bss_pkg::CMD_CONFIGURE_BIT]) begin
						burst_d = bss_pkg::BURST_RST;
						pace_d = 1'b0;
						oom_d = 1'b0;
					end
				end
				bss_pkg::OFF_LIMIT: begin
					limSel_d = pwdata[bss_pkg::LIM_SEL_LO +: 2];
				end
				default: begin
				end
			endcase
		end
		// read path
		rdata_d = 32'h00000000;
		if (rdAcc) begin
			unique case (paddr)
				bss_pkg::OFF_BURST: begin
					unique case (limSel_q)
						bss_pkg::BSS_LIM_MIN: rdata_d = 32'(bss_pkg::BURST_MIN);
						bss_pkg::BSS_LIM_MAX: rdata_d = 32'(bss_pkg::BURST_MAX);
						default: rdata_d = 32'(burst_q);
					endcase
				end
				bss_pkg::OFF_PERIOD: begin
					unique case (limSel_q)
						bss_pkg::BSS_LIM_MIN: rdata_d = 32'(bss_pkg::PERIOD_MIN_US);
						bss_pkg::BSS_LIM_MAX: rdata_d = 32'(bss_pkg::PERIOD_MAX_US);
						default: rdata_d = 32'(period_q);
					endcase
				end
				bss_pkg::OFF_CTRL: begin
					rdata_d[bss_pkg::CTRL_PACE_BIT] = pace_q;
					rdata_d[bss_pkg::CTRL_FUNC_LO +: 2] = func_q;
				end
				bss_pkg::OFF_STATUS: begin
					rdata_d = {29'h00000000, oom_q, seqBusy, pace_q};
				end
				bss_pkg::OFF_LIMIT: begin
					rdata_d = {30'h00000000, limSel_q};
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
		ready_d = psel && penable && !ready_q;
		err_d = psel && penable && !ready_q && !known;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			burst_q <= bss_pkg::BURST_RST;
			period_q <= bss_pkg::PERIOD_RST_US;
			pace_q <= 1'b0;
			func_q <= bss_pkg::BSS_DC_VOLTS_FUNCTION;
			limSel_q <= bss_pkg::BSS_LIM_PRESENT;
			oom_q <= 1'b0;
			rdata_q <= 32'h00000000;
			ready_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			burst_q <= burst_d;
			period_q <= period_d;
			pace_q <= pace_d;
			func_q <= func_d;
			limSel_q <= limSel_d;
			oom_q <= oom_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
		end
	end
	// ==========================================================
	// burst sequencer
	bss_pkg::bss_state_t state_q, state_d;
	logic [bss_pkg::BURST_W-1:0] left_q, left_d;
	logic start_q, start_d;
	logic step_q, step_d;
	logic reload;
	// registered so the busy output comes from a flip-flop
	logic busy_q, busy_d;
	// a trigger during a burst is ignored; trigger delay lives upstream
	always_comb begin
		state_d = state_q;
		left_d = left_q;
		start_d = 1'b0;
		step_d = 1'b0;
		reload = 1'b0;
		unique case (state_q)
			bss_pkg::BSS_IDLE: begin
				if (trigAccepted) begin
					left_d = burst_q;
					state_d = bss_pkg::BSS_START;
				end
			end
			bss_pkg::BSS_START: begin
				if (!engineBusy) begin
					start_d = 1'b1;
					step_d = scanMode;
					reload = 1'b1;
					state_d = bss_pkg::BSS_BUSY;
				end
			end
			bss_pkg::BSS_BUSY: begin
				if (readingDone) begin
					left_d = left_q - 1'b1;
					if (left_q == bss_pkg::BURST_MIN) begin
						state_d = bss_pkg::BSS_IDLE;
					end else if (pace_q == 1'b0) begin
						state_d = bss_pkg::BSS_START;
					end else begin
						state_d = bss_pkg::BSS_PACE;
					end
				end
			end
			bss_pkg::BSS_PACE: begin
				if (tif.expired) begin
					state_d = bss_pkg::BSS_START;
				end
			end
		endcase
		busy_d = (state_d != bss_pkg::BSS_IDLE);
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= bss_pkg::BSS_IDLE;
			left_q <= '0;
			start_q <= 1'b0;
			step_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			left_q <= left_d;
			start_q <= start_d;
			step_q <= step_d;
			busy_q <= busy_d;
		end
	end
	assign seqBusy = busy_q;
	assign tif.reload = reload;
	assign tif.periodUs = period_q;
	// ==========================================================
	// outputs
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	assign readingStart = start_q;
	assign scanStep = step_q;
	assign burstActive = seqBusy;
	assign measFunction = func_q;
	assign outOfMemory = oom_q;
endmodule : bss_sequencer

/* File: common/bss_pkg.sv */
// package of constants and types for the burst sample sequencer
package bss_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFF_BURST = 12'h000;
	localparam logic [11:0] OFF_PERIOD = 12'h004;
	localparam logic [11:0] OFF_CTRL = 12'h008;
	localparam logic [11:0] OFF_CMD = 12'h00c;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_LIMIT = 12'h014;
	// ==========================================================
	// field positions
	localparam int CTRL_PACE_BIT = 0;
	localparam int CTRL_FUNC_LO = 4;
	localparam int CMD_CONFIGURE_BIT = 0;
	localparam int CMD_CLR_ERR_BIT = 1;
	localparam int LIM_SEL_LO = 0;
	// ==========================================================
	// burst length limits
	localparam int BURST_W = 24;
	localparam logic [23:0] BURST_MIN = 24'h000001;
	localparam logic [23:0] BURST_MAX = 24'hffffff;
	localparam logic [23:0] BURST_RST = 24'h000001;
	// ==========================================================
	// sample period in microsecond ticks
	localparam int PERIOD_W = 17;
	localparam logic [16:0] PERIOD_MIN_US = 17'h0004c;
	localparam logic [16:0] PERIOD_MAX_US = 17'h0fffe;
	localparam logic [16:0] PERIOD_RST_US = 17'h0c350;
	localparam int CLK_MHZ = 100;
	localparam int TICK_NS = 1000;
	localparam int CLK_NS = 1000 / CLK_MHZ;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	// ==========================================================
	// limit query selector
	typedef enum logic [1:0] {
		BSS_LIM_PRESENT = 2'b00,
		BSS_LIM_MIN = 2'b01,
		BSS_LIM_MAX = 2'b10
	} bss_lim_t;
	// pacing source codes
	typedef enum logic [0:0] {
		BSS_IMMEDIATE_PACING = 1'b0,
		BSS_TIMED_PACING = 1'b1
	} bss_pace_t;
	// measurement function codes
	typedef enum logic [1:0] {
		BSS_DC_VOLTS_FUNCTION = 2'b00,
		BSS_AC_VOLTS_FUNCTION = 2'b01,
		BSS_FOUR_WIRE_OHMS = 2'b10,
		BSS_DC_VOLTS_ALIAS = 2'b11
	} bss_func_t;
	// sequencer states
	typedef enum logic [1:0] {
		BSS_IDLE = 2'b00,
		BSS_START = 2'b01,
		BSS_BUSY = 2'b10,
		BSS_PACE = 2'b11
	} bss_state_t;
endpackage : bss_pkg

/* File: common/bss_timer_if.sv */
// interface between sequencer and sample period timer
`timescale 1ns/10ps
interface bss_timer_if;
	logic reload;
	logic [bss_pkg::PERIOD_W-1:0] periodUs;
	logic expired;
	modport ctrl (output reload, output periodUs, input expired);
	modport timer (input reload, input periodUs, output expired);
endinterface : bss_timer_if

/* File: core/bss_tick_gen.sv */
// fixed rate microsecond tick from the core clock
`timescale 1ns/10ps
module bss_tick_gen #(
	parameter int CYCLES = bss_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// tick out
	output logic tick
);
	// ==========================================================
	// elaboration check
	if (CYCLES < 2 || CYCLES > 255) begin : g_bad
		$error("tick divider out of range");
	end
	logic [7:0] cnt_q, cnt_d;
	logic tick_q, tick_d;
	always_comb begin
		tick_d = (cnt_q == 8'(CYCLES - 1));
		cnt_d = tick_d ? 8'h00 : cnt_q + 8'h01;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick = tick_q;
endmodule : bss_tick_gen

/* File: core/bss_period_timer.sv */
// sample period down counter, reloaded at each reading start
`timescale 1ns/10ps
module bss_period_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// microsecond tick
	input wire logic tick,
	// sequencer side
	bss_timer_if.timer tif
);
	// ==========================================================
	// counter
	logic [bss_pkg::PERIOD_W-1:0] cnt_q, cnt_d;
	logic exp_q, exp_d;
	always_comb begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (tif.reload) begin
			cnt_d = tif.periodUs;
		end else if (tick && cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			exp_d = (cnt_q == {{(bss_pkg::PERIOD_W-1){1'b0}}, 1'b1});
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end
	assign tif.expired = exp_q;
endmodule : bss_period_timer

/* File: tb/bss_engine_model.sv */
// measurement engine model facing the sequencer
`timescale 1ns/10ps
module bss_engine_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// sequencer side
	input wire logic readingStart,
	input wire logic [15:0] busyCycles,
	output logic engineBusy,
	output logic readingDone
);
	// ==========================================================
	// conversion time stands in for the aperture, kept below the period
	int cnt;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			engineBusy <= 1'b0;
			readingDone <= 1'b0;
		end else begin
			readingDone <= 1'b0;
			if (readingStart) begin
				engineBusy <= 1'b1;
				cnt <= busyCycles;
			end else if (cnt == 1) begin
				engineBusy <= 1'b0;
				readingDone <= 1'b1;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : bss_engine_model

/* File: tb/bss_chk.sv */
// port checker of the burst sample sequencer
`timescale 1ns/10ps
module bss_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// sequencer
	input wire logic trigAccepted,
	input wire logic engineBusy,
	input wire logic readingDone,
	input wire logic readingStart,
	input wire logic burstActive,
	input wire logic scanStep,
	input wire logic scanMode,
	input wire logic [1:0] measFunction,
	input wire logic outOfMemory
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// sequences
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_trig;
		trigAccepted && !burstActive && !engineBusy;
	endsequence
	// ==========================================================
	// properties
	property p_ready;
		s_acc |=> pready ##1 !pready;
	endproperty
	property p_err;
		s_acc |=> pslverr == ($past(paddr) > 12'h014);
	endproperty
	property p_first;
		s_trig |=> burstActive ##[1:2] readingStart;
	endproperty
	property p_active;
		readingStart |-> burstActive;
	endproperty
	property p_end;
		$fell(burstActive) |-> $past(readingDone) || $past(readingDone, 2);
	endproperty
	property p_step;
		scanStep |-> readingStart;
	endproperty
	property p_scan;
		readingStart && scanMode && $past(scanMode) |-> scanStep;
	endproperty
	property p_free;
		readingStart |-> !$past(engineBusy) ##1 !readingStart;
	endproperty
	property p_oom;
		s_acc and (pwrite && paddr == bss_pkg::OFF_BURST && pwdata[23:0] == bss_pkg::BURST_MAX)
			|=> ##[0:1] outOfMemory;
	endproperty
	property p_func;
		measFunction != 2'b11;
	endproperty
	a_ready: assert property (p_ready) else $error("pready late or long");
	a_err: assert property (p_err) else $error("pslverr wrong");
	a_first: assert property (p_first) else $error("first reading waited");
	a_active: assert property (p_active) else $error("reading outside burst");
	a_end: assert property (p_end) else $error("burst ended without done");
	a_step: assert property (p_step) else $error("stray channel step");
	a_scan: assert property (p_scan) else $error("missing channel step");
	a_free: assert property (p_free) else $error("start while busy");
	a_oom: assert property (p_oom) else $error("oom not set");
	a_func: assert property (p_func) else $error("bad function code");
endmodule : bss_chk
bind bss_sequencer bss_chk chk_u (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.trigAccepted, .engineBusy, .readingDone, .readingStart, .burstActive, .scanStep, .scanMode, .measFunction,
	.outOfMemory);

/* File: tb/bss_tb_top.sv */
// testbench top of the burst sample sequencer
`timescale 1ns/10ps
module burst_sample_sequencer_tb_top;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic trigAccepted, engineBusy, readingDone, readingStart, burstActive, scanStep, scanMode, outOfMemory;
	logic [1:0] measFunction;
	logic [15:0] busyCycles;
	int n_fail, n_tests, nStarts, nSteps, cyc, lastCyc, gap;
	bss_sequencer dut_u (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.trigAccepted, .engineBusy, .readingDone, .readingStart, .burstActive, .scanStep, .scanMode, .measFunction,
		.outOfMemory);
	bss_engine_model eng_u (.core_clk, .rst_b, .readingStart, .busyCycles, .engineBusy, .readingDone);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========================================================
	// reading monitor
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (readingStart === 1'b1) begin
			nStarts <= nStarts + 1;
			gap <= cyc - lastCyc;
			lastCyc <= cyc;
		end
		if (scanStep === 1'b1) nSteps <= nSteps + 1;
	end
	// ==========================================================
	// helpers
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) n_fail++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(string nm, logic [11:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, r, exp);
	endtask : rd
	task burst(logic [31:0] n);
		int k;
		apb(1'b1, bss_pkg::OFF_BURST, n);
		@(posedge core_clk);
		nStarts = 0;
		nSteps = 0;
		trigAccepted <= 1'b1;
		@(posedge core_clk);
		trigAccepted <= 1'b0;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (burstActive !== 1'b0 && k < 30000);
		if (k >= 30000) n_fail++;
		repeat (2) @(posedge core_clk);
	endtask : burst
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// ==========================================================
	// scenarios
	task t_reset;
		rd("burst", bss_pkg::OFF_BURST, 32'h1);
		rd("period", bss_pkg::OFF_PERIOD, 32'hc350);
		rd("status", bss_pkg::OFF_STATUS, 32'h0);
		chk("func", measFunction, 32'h0);
	endtask : t_reset
	task t_limits;
		apb(1'b1, bss_pkg::OFF_LIMIT, 32'h1);
		rd("burstMin", bss_pkg::OFF_BURST, 32'h1);
		rd("periodMin", bss_pkg::OFF_PERIOD, 32'h4c);
		apb(1'b1, bss_pkg::OFF_LIMIT, 32'h2);
		rd("burstMax", bss_pkg::OFF_BURST, 32'hffffff);
		rd("periodMax", bss_pkg::OFF_PERIOD, 32'hfffe);
		apb(1'b1, bss_pkg::OFF_LIMIT, 32'h0);
		apb(1'b1, bss_pkg::OFF_PERIOD, 32'h0);
		rd("periodLo", bss_pkg::OFF_PERIOD, 32'h4c);
		apb(1'b1, bss_pkg::OFF_PERIOD, 32'h1ffff);
		rd("periodHi", bss_pkg::OFF_PERIOD, 32'hfffe);
		apb(1'b1, bss_pkg::OFF_BURST, 32'h0);
		rd("burstZero", bss_pkg::OFF_BURST, 32'h1);
	endtask : t_limits
	task t_func;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, bss_pkg::OFF_CTRL, 32'(i) << 4);
			chk("func", measFunction, (i == 3) ? 32'h0 : 32'(i));
		end
	endtask : t_func
	task t_oom;
		apb(1'b1, bss_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, bss_pkg::OFF_BURST, 32'hffffff);
		chk("oom", outOfMemory, 32'h1);
		apb(1'b1, bss_pkg::OFF_CMD, 32'h1);
		rd("burstCfg", bss_pkg::OFF_BURST, 32'h1);
		rd("statusCfg", bss_pkg::OFF_STATUS, 32'h0);
		apb(1'b1, bss_pkg::OFF_BURST, 32'hffffff);
		chk("oomAgain", outOfMemory, 32'h1);
		apb(1'b1, bss_pkg::OFF_CMD, 32'h2);
		chk("oomClr", outOfMemory, 32'h0);
		rd("burstKeep", bss_pkg::OFF_BURST, 32'hffffff);
	endtask : t_oom
	task t_imm;
		busyCycles <= 16'd20;
		burst(32'h3);
		chk("immStarts", nStarts, 32'h3);
		chk("immGap", 32'(gap <= 30), 32'h1);
		chk("immSteps", nSteps, 32'h0);
	endtask : t_imm
	task t_timed;
		busyCycles <= 16'd5;
		scanMode <= 1'b1;
		apb(1'b1, bss_pkg::OFF_PERIOD, 32'h4c);
		apb(1'b1, bss_pkg::OFF_CTRL, 32'h1);
		rd("paceTimed", bss_pkg::OFF_STATUS, 32'h1);
		burst(32'h3);
		chk("timStarts", nStarts, 32'h3);
		chk("timGap", 32'(gap >= 7500 && gap <= 7720), 32'h1);
		chk("timSteps", nSteps, 32'h3);
	endtask : t_timed
	task t_unmapped;
		apb(1'b0, 12'h020, 32'h0);
		chk("badData", r, 32'h0);
		chk("badErr", e, 32'h1);
	endtask : t_unmapped
	// ==========================================================
	// main sequence and watchdog
	initial begin
		{psel, penable, pwrite, trigAccepted, scanMode} = 5'h00;
		{paddr, pwdata, busyCycles} = '0;
		{n_fail, n_tests, nStarts, nSteps, cyc, lastCyc, gap} = '0;
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_limits();
		t_func();
		t_oom();
		t_imm();
		t_timed();
		t_unmapped();
		stop_test();
	end
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end
endmodule : burst_sample_sequencer_tb_top
